// file: hdl/scb_pkg.sv
package scb_pkg;
  localparam int BYTE_BITS = 8;
  localparam int MAX_BYTES = 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_HIZ_NS = 1000;
  // Longest float delay, rounded down to whole cycles
  localparam int HIZ_CYCLES = T_HIZ_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  // Cycles from a pin change to the registered outputs reacting
  localparam int REACT_CYCLES = SYNC_STAGES + 1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_OVER = 2'h3;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : scb_pkg

// file: hdl/scb_sync.sv
`timescale 1ns/1ps
module scb_sync
  import scb_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
)(
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Pins from outside the domain
  output logic [WIDTH-1:0] sync_out // Two-flop synchronised copy
);
  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s state;
  sync_s next_state;

  initial
  begin
    if (WIDTH < 1)
      $error("scb_sync needs at least one bit");
  end

  // First stage only feeds the second one
  always_comb
  begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  // Reset to the idle pin levels
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= '{meta: INIT, stable: INIT};
    else
      state <= next_state;
  end

  assign sync_out = state.stable;
endmodule : scb_sync

// file: hdl/serial_control_bus_target.sv
`timescale 1ns/1ps
module serial_control_bus_target
  import scb_pkg::*;
(
  input wire logic clk_in, // 25 MHz system clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic chip_select_low_in, // Select pin, active low
  input wire logic serial_clock_in, // Host serial clock pin
  input wire logic command_data_in, // Host command data pin
  input wire logic [15:0] reply_word_in, // Reply bytes, first in [15:8]
  output logic reply_data_out, // Reply data pin value
  output logic reply_oe_n_out, // Reply pin enable, low drives
  output logic [15:0] cmd_word_out, // Command bytes, first in [15:8]
  output logic [1:0] cmd_len_out, // Byte count of last command
  output logic cmd_valid_out, // One-cycle execute strobe
  output logic cmd_error_out // One-cycle strobe, malformed frame
);
  typedef struct packed
  {
    logic cs_q;
    logic sclk_q;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] rx_shift;
    logic [15:0] rx_word;
    logic [7:0] tx_shift;
    logic tx_pending;
    logic oe_n;
    logic rdata;
    logic [15:0] cmd_word;
    logic [1:0] cmd_len;
    logic cmd_valid;
    logic cmd_error;
  } target_s;

  target_s state;
  target_s next_state;
  logic [2:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic data_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;

  initial
  begin
    if (REACT_CYCLES > HIZ_CYCLES)
      $error("Reply float would exceed its longest delay");
  end

  // Reply byte chosen by index; zeros once the reply is used up
  function automatic logic [7:0] reply_byte(input logic [15:0] word,
                                            input logic [1:0] idx);
    logic [7:0] b;
    b = BYTE_RESET;
    if (idx == BYTES_NONE)
      b = word[15:8];
    else if (idx == BYTES_ONE)
      b = word[7:0];
    return b;
  endfunction : reply_byte

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  ////////////////////////////////////////////////////////////////////////

  // All three pins share one synchroniser so their order is kept
  scb_sync #(
    .WIDTH(3),
    .INIT(3'h4)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({chip_select_low_in, serial_clock_in, command_data_in}),
    .sync_out(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign data_s = pins_s[0];

  // Edges only count while selected; the level at select is no edge
  assign sclk_rise = !cs_s && !state.cs_q && sclk_s && !state.sclk_q;
  assign sclk_fall = !cs_s && !state.cs_q && !sclk_s && state.sclk_q;
  assign cs_rise = cs_s && !state.cs_q;
  assign cs_fall = !cs_s && state.cs_q;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  ////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_state = state;
    next_state.cs_q = cs_s;
    next_state.sclk_q = sclk_s;
    next_state.cmd_valid = 1'b0;
    next_state.cmd_error = 1'b0;
    if (cs_s)
    begin
      // Deselected: counters cleared so the next frame is aligned
      next_state.bit_cnt = 3'h0;
      next_state.byte_cnt = BYTES_NONE;
      next_state.tx_pending = 1'b0;
      next_state.oe_n = 1'b1;
      next_state.rdata = 1'b0;
      if (cs_rise)
      begin
        // Act only at frame end, and only on whole bytes
        if (state.bit_cnt == 3'h0 && (state.byte_cnt == BYTES_ONE ||
            state.byte_cnt == BYTES_TWO))
        begin
          next_state.cmd_valid = 1'b1;
          next_state.cmd_word = state.rx_word;
          next_state.cmd_len = state.byte_cnt;
        end
        else if (state.bit_cnt != 3'h0 || state.byte_cnt == BYTES_OVER)
          next_state.cmd_error = 1'b1;
      end
    end
    else
    begin
      if (cs_fall)
      begin
        next_state.rx_word = WORD_RESET;
        next_state.tx_shift = reply_byte(reply_word_in, BYTES_NONE);
      end
      // Capture most significant bit first
      if (sclk_rise)
      begin
        next_state.rx_shift = {state.rx_shift[6:0], data_s};
        next_state.bit_cnt = state.bit_cnt + 3'h1;
        next_state.tx_pending = 1'b1;
        if (state.bit_cnt == BIT_LAST)
        begin
          // Extra bytes are not stored; they mark the frame bad
          if (state.byte_cnt == BYTES_NONE)
            next_state.rx_word[15:8] = {state.rx_shift[6:0], data_s};
          else if (state.byte_cnt == BYTES_ONE)
            next_state.rx_word[7:0] = {state.rx_shift[6:0], data_s};
          if (state.byte_cnt != BYTES_OVER)
            next_state.byte_cnt = state.byte_cnt + 2'h1;
          next_state.tx_shift = reply_byte(reply_word_in,
                                           state.byte_cnt + 2'h1);
          next_state.tx_pending = 1'b0;
        end
      end
      // Next reply bit goes out on the falling edge, for host rise
      if (sclk_fall && state.tx_pending)
      begin
        next_state.tx_shift = {state.tx_shift[6:0], 1'b0};
        next_state.tx_pending = 1'b0;
      end
      // Drive only once the clock has been seen low
      if (!sclk_s)
        next_state.oe_n = 1'b0;
      next_state.rdata = next_state.tx_shift[7];
    end
  end

  // Reset leaves the bus idle: deselected, clock high, output floating
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= '0;
      state.cs_q <= 1'b1;
      state.sclk_q <= 1'b1;
      state.oe_n <= 1'b1;
    end
    else
      state <= next_state;
  end

  // Outputs come straight from state flops
  assign reply_data_out = state.rdata;
  assign reply_oe_n_out = state.oe_n;
  assign cmd_word_out = state.cmd_word;
  assign cmd_len_out = state.cmd_len;
  assign cmd_valid_out = state.cmd_valid;
  assign cmd_error_out = state.cmd_error;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  bit_capture_a: assert property (
    sclk_rise |=> state.rx_shift == {$past(state.rx_shift[6:0]),
                                     $past(data_s)})
    else $error("Command bit not captured on rising clock");

  first_byte_msb_a: assert property (
    sclk_rise && state.bit_cnt == BIT_LAST && state.byte_cnt == BYTES_NONE
    |=> state.rx_word[15:8] == {$past(state.rx_shift[6:0]), $past(data_s)})
    else $error("First command byte not stored msb first");

  exec_at_end_a: assert property (
    cmd_valid_out |-> $past(cs_rise) && cs_s && !$past(cmd_valid_out))
    else $error("Command executed outside frame end");

  exec_word_a: assert property (
    cs_rise && state.bit_cnt == 3'h0 && state.byte_cnt == BYTES_TWO
    |=> cmd_valid_out && cmd_len_out == BYTES_TWO
        && cmd_word_out == $past(state.rx_word))
    else $error("Two-byte command not delivered at frame end");

  reply_shift_a: assert property (
    sclk_fall && state.tx_pending && !sclk_rise
    |=> reply_data_out == $past(state.tx_shift[6]))
    else $error("Reply bit not advanced msb first");

  float_off_a: assert property (
    $rose(chip_select_low_in) |-> ##[1:4] reply_oe_n_out)
    else $error("Reply output not floated after deselect");

  drive_after_low_a: assert property (
    $fell(reply_oe_n_out) |-> $past(!sclk_s) && $past(!cs_s))
    else $error("Reply output driven without clock low");

  counter_clear_a: assert property (
    cs_s |=> state.bit_cnt == 3'h0 && state.byte_cnt == BYTES_NONE)
    else $error("Bit counter not cleared on deselect");

  select_no_edge_a: assert property (
    cs_fall |=> state.bit_cnt == 3'h0 [*2])
    else $error("Selection at clock level counted as an edge");

  one_byte_cov: cover property (
    cmd_valid_out && cmd_len_out == BYTES_ONE);
  two_byte_cov: cover property (
    cmd_valid_out && cmd_len_out == BYTES_TWO);
  high_idle_cov: cover property (cs_fall && sclk_s);
  error_cov: cover property (cmd_error_out);
endmodule : serial_control_bus_target

// file: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  output logic cs_n_out, // Select, active low
  output logic sclk_out, // Serial clock
  output logic mosi_out, // Command data
  input wire logic miso_in // Resolved reply pin
);
  logic [15:0] rx;
  // Idle pins; select high so the target starts deselected
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
    rx = 16'h0000;
  end
  ////////////////////////////////////////
  // One frame of n clocks, 320 ns period; offset keeps phase unrelated
  task automatic frame(input logic [15:0] w, input int n, input logic idle);
    sclk_out = idle;
    #167 cs_n_out = 1'b0;
    #160;
    for (int i = 0; i < n; i++)
    begin
      sclk_out = 1'b0;
      mosi_out = w[15 - (i % 16)];
      #160 sclk_out = 1'b1;
      rx = {rx[14:0], miso_in};
      #160;
    end
    sclk_out = idle;
    // Data no longer held, so it must not keep the last bit
    mosi_out = ~mosi_out;
    #160 cs_n_out = 1'b1;
    #1200;
  endtask : frame
endmodule : host_model

// file: verif/serial_control_bus_target_tb.sv
`timescale 1ns/1ps
module serial_control_bus_target_tb;
  import scb_pkg::*;
  logic clk_in, rst_n_in, flip, reply_data, reply_oe_n, cmd_valid, cmd_error;
  logic [15:0] reply_word, last_word, w, cmd_word;
  logic [1:0] last_len, cmd_len;
  logic [31:0] seed;
  logic [18:0] expq[$];
  wire cs_n, sclk, mosi, pin;
  int n_fail, tests_run, cycles, n;
  int lens[8] = '{8, 16, 5, 24, 0, 16, 8, 16};
  // Released pin toggles so a stale value cannot pass
  assign pin = reply_oe_n ? flip : reply_data;
  serial_control_bus_target uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .chip_select_low_in(cs_n), .serial_clock_in(sclk),
    .command_data_in(mosi), .reply_word_in(reply_word),
    .reply_data_out(reply_data), .reply_oe_n_out(reply_oe_n),
    .cmd_word_out(cmd_word), .cmd_len_out(cmd_len),
    .cmd_valid_out(cmd_valid), .cmd_error_out(cmd_error));
  host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
    .miso_in(pin));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input string nm, input logic [18:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // Clock and the floating-pin pattern
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) flip <= ~flip;
  // Hang guard, a bit over twice the expected run of about 2200 cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  // Each strobe takes the oldest note; read mid-cycle, where it is settled
  always @(negedge clk_in)
    if (cmd_valid === 1'b1 || cmd_error === 1'b1)
    begin
      if (expq.size() == 0)
        check("stray strobe", 19'h1, 19'h0);
      else
        check("cmd", {cmd_error, cmd_len, cmd_word}, expq.pop_front());
    end
  // Reply pin driven at every sampled edge of a frame
  always @(posedge sclk)
    if (cs_n === 1'b0)
      check("reply enable", {18'h0, reply_oe_n}, 19'h0);
  ////////////////////////////////////////
  // Frames of every length class, both clock idle levels, random data
  initial
  begin
    flip = 1'b0;
    rst_n_in = 1'b0;
    reply_word = 16'h0000;
    seed = 32'h21f07f63;
    last_word = 16'h0000;
    last_len = 2'h0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    for (int t = 0; t < 16; t++)
    begin
      @(negedge clk_in);
      n = lens[t % 8];
      seed = xs(seed);
      reply_word = seed[15:0];
      seed = xs(seed);
      w = seed[15:0];
      if (n == 8 || n == 16)
      begin
        last_word = (n == 8) ? {w[15:8], 8'h00} : w;
        last_len = 2'(n / 8);
      end
      if (n != 0)
        expq.push_back({(n % 8 != 0) || (n > 16), last_len, last_word});
      // Each entry of lens is run once with each clock idle level
      host.frame(w, n, t[3] ^ t[0]);
      check("pending", 19'(expq.size()), 19'h0);
      check("release", {18'h0, reply_oe_n}, 19'h1);
      if (n == 8)
        check("reply", {11'h0, host.rx[7:0]}, {11'h0, reply_word[15:8]});
      if (n == 16)
        check("reply", {3'h0, host.rx}, {3'h0, reply_word});
      $display("test %0d of %0d clocks done", t, n);
    end
    report_and_stop();
  end
endmodule : serial_control_bus_target_tb
